// *** hdl/bfx_consts.svh ***
/*
  constants of the bit-field execute unit: apb offsets, field positions,
  codes and reset values.
  assumes: included by bare name from the package and the design module.
*/
// Operation
// (RQ1) register into bank field merges low bits only
// (RQ2) bank field into register is zero-extended
// (RQ3) bank select registers are write-only destinations
// (RQ4) carry flag is source only, add-set
// (RQ5) codes 00-17 octal select registers
// (RQ6) codes 20-27 select left bank field
// (RQ7) codes 30-37 select right bank field
// (RQ8) move copies, source stays unchanged
// (RQ9) register to register rotates right, else length
// (RQ10) program moves bank to bank as 8 bits
// (RQ11) add sums source and aux, sets carry
// (RQ12) source and aux kept unless destination
// (RQ13) and stores source and aux
// (RQ14) xor stores source xor aux
// (RQ15) indirect execute target from address plus sum
// (RQ16) indirect execute leaves program counter unchanged
// (RQ17) literal transfer stores 8 or 5 bits
// (RQ18) opcode 0-7 selects the eight operations
// (RQ19) bit 0 is most significant bit
// (RQ20) one instruction per instruction cycle
// (RQ21) unassigned codes ignore writes, read zero
`ifndef BFX_CONSTS_SVH
`define BFX_CONSTS_SVH

// ---------------------------------------------------------------
// apb register offsets (byte addresses)
// ---------------------------------------------------------------
`define BFX_OFS_INSTR    8'h00
`define BFX_OFS_STATUS   8'h04
`define BFX_OFS_TARGET   8'h08
`define BFX_OFS_SELECTS  8'h0C
`define BFX_OFS_REGBASE  8'h40
`define BFX_OFS_REGLAST  8'h7C

// ---------------------------------------------------------------
// status word layout
// ---------------------------------------------------------------
`define BFX_STAT_CARRY   16

// ---------------------------------------------------------------
// instruction fields (hardware bit numbers)
// ---------------------------------------------------------------
`define BFX_OP_HI        15
`define BFX_OP_LO        13
`define BFX_SRC_HI       12
`define BFX_SRC_LO       8
`define BFX_RL_HI        7
`define BFX_RL_LO        5
`define BFX_DST_HI       4
`define BFX_DST_LO       0

// ---------------------------------------------------------------
// source / destination register codes
// ---------------------------------------------------------------
`define BFX_CODE_AUX     5'h00
`define BFX_CODE_LSEL    5'h07
`define BFX_CODE_CARRY   5'h08
`define BFX_CODE_EXTRA   5'h09
`define BFX_CODE_RSEL    5'h0F
`define BFX_IDX_EXTRA    3'h7

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define BFX_RST_BYTE     8'h00
`define BFX_RST_INSTR    16'h0000
`define BFX_RST_PC       13'h0000

`endif

// *** hdl/bfx_pkg.sv ***
/*
  types of the bit-field execute unit: opcode enumeration and the
  packed state of the design module.
  assumes: bfx_consts.svh is on the include path.
*/
`include "bfx_consts.svh"

package bfx_pkg;

  // ---------------------------------------------------------------
  // operation codes, in encoding order 0..7
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_MOVE, OP_ADD, OP_AND, OP_XOR,
    OP_INDIRECT_EXECUTE, OP_NONZERO_BRANCH,
    OP_LITERAL_TRANSFER, OP_JUMP
  } bfx_op_t;

  // ---------------------------------------------------------------
  // complete state of the execute unit
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [15:0]      instr;        // last instruction written
    logic             go;           // execute pending this cycle
    logic [7:0][7:0]  regs;         // 0 aux, 1-6 general, 7 extra
    logic             carry;        // carry flag
    logic [7:0]       lsel;         // left bank select
    logic [7:0]       rsel;         // right bank select
    logic [12:0]      pc;           // program counter
    logic [12:0]      target;       // last indirect execute target
    logic [7:0]       left_wdata;   // left bank write byte
    logic             left_we;      // left bank write strobe
    logic [7:0]       right_wdata;  // right bank write byte
    logic             right_we;     // right bank write strobe
    logic [31:0]      prdata;       // apb read data
    logic             pready;       // apb ready
    logic             pslverr;      // apb error
  } bfx_state_t;

endpackage : bfx_pkg

// *** hdl/bfx_exec_unit.sv ***
/*
  execute stage of an 8-bit bit-field controller: decodes source and
  destination codes, runs move/add/and/xor/indirect execute/literal
  transfer/branch/jump, merges bank fields, rotates and keeps carry.
  assumes: apb master on pclk; bank read bytes are synchronous inputs
  that follow the select outputs combinationally.
*/
`timescale 1ns/100ps
`include "bfx_consts.svh"

module bfx_exec_unit #(
  parameter int ADDR_W = 8        // apb address width
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [7:0]        left_bank_rdata,
  input  wire logic [7:0]        right_bank_rdata,
  output logic      [7:0]        left_bank_select_reg,
  output logic      [7:0]        right_bank_select_reg,
  output logic      [7:0]        left_bank_wdata,
  output logic                   left_bank_we,
  output logic      [7:0]        right_bank_wdata,
  output logic                   right_bank_we
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  bfx_pkg::bfx_state_t st_reg;    // registered state
  bfx_pkg::bfx_state_t st_next;   // next state

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // mask of a field length; length code 0 means 8 bits
  function automatic logic [7:0] len_mask(input logic [2:0] len);
    logic [8:0] one;
    one = 9'h001 << ((len == 3'h0) ? 4'h8 : {1'b0, len});
    return 8'(one - 9'h001);
  endfunction : len_mask

  // field whose lsb sits at position pos, bit 0 being the msb
  function automatic logic [7:0] field_get(input logic [7:0] b,
                                           input logic [2:0] pos,
                                           input logic [2:0] len);
    return (b >> (3'h7 - pos)) & len_mask(len); // RQ19 RQ2
  endfunction : field_get

  // merge the low bits of v into the field, rest untouched
  function automatic logic [7:0] field_put(input logic [7:0] b,
                                           input logic [2:0] pos,
                                           input logic [2:0] len,
                                           input logic [7:0] v);
    logic [7:0] m;
    m = 8'(len_mask(len) << (3'h7 - pos));
    return (b & ~m) | (8'(v << (3'h7 - pos)) & m); // RQ1
  endfunction : field_put

  // right rotation of a byte
  function automatic logic [7:0] rot_right(input logic [7:0] b,
                                           input logic [2:0] n);
    logic [15:0] w;
    w = {b, b} >> n;
    return w[7:0];
  endfunction : rot_right

  // register read by source code
  function automatic logic [7:0] reg_read(input logic [4:0] c,
                                          input logic [7:0][7:0] r,
                                          input logic cy);
    logic [7:0] v;
    v = 8'h00;
    if (c <= 5'h06) begin
      v = r[c[2:0]];                             // RQ5
    end else if (c == `BFX_CODE_CARRY) begin
      v = {7'h00, cy};                           // RQ4
    end else if (c == `BFX_CODE_EXTRA) begin
      v = r[`BFX_IDX_EXTRA];
    end
    // select codes and unassigned codes read zero  RQ3 RQ21
    return v;
  endfunction : reg_read

  // ---------------------------------------------------------------
  // instruction decode
  // ---------------------------------------------------------------
  bfx_pkg::bfx_op_t op;           // decoded operation
  logic [4:0]       s_code;       // source code field
  logic [2:0]       rl;           // rotate / length field
  logic [4:0]       d_code;       // destination code field
  logic [7:0]       lit8;         // 8-bit literal
  logic [7:0]       lit5;         // 5-bit literal, zero-extended

  assign op     = bfx_pkg::bfx_op_t'(st_reg.instr[`BFX_OP_HI:`BFX_OP_LO]);
  assign s_code = st_reg.instr[`BFX_SRC_HI:`BFX_SRC_LO];
  assign rl     = st_reg.instr[`BFX_RL_HI:`BFX_RL_LO];
  assign d_code = st_reg.instr[`BFX_DST_HI:`BFX_DST_LO];
  assign lit8   = st_reg.instr[7:0];
  assign lit5   = {3'h0, st_reg.instr[4:0]};

  // ---------------------------------------------------------------
  // next-state logic: apb slave and instruction execution
  // ---------------------------------------------------------------
  always_comb begin
    logic [7:0] src;              // source operand after shaping
    logic [7:0] res;              // result byte
    logic [8:0] sum;              // add with carry out
    logic [4:0] wcode;            // code being written
    logic       wr;               // a destination write happens
    logic [7:0] sbank;            // source bank byte
    logic [7:0] wbank;            // destination bank byte
    logic [5:0] ridx;             // apb register window index
    logic [7:0] xsum;             // indirect execute sum
    src   = 8'h00;
    res   = 8'h00;
    sum   = 9'h000;
    wcode = d_code;
    wr    = 1'b0;
    sbank = s_code[3] ? right_bank_rdata : left_bank_rdata;
    wbank = 8'h00;
    ridx  = 6'h00;
    xsum  = 8'h00;
    st_next          = st_reg;
    st_next.go       = 1'b0;
    st_next.left_we  = 1'b0;
    st_next.right_we = 1'b0;
    st_next.pready   = psel & ~penable;
    st_next.pslverr  = 1'b0;

    // apb setup phase: decode and register read data
    if (psel && !penable) begin
      st_next.prdata = 32'h0000_0000;
      ridx = 6'(paddr[7:2]);
      if (8'(paddr) == `BFX_OFS_INSTR) begin
        st_next.prdata = {16'h0000, st_reg.instr};
      end else if (8'(paddr) == `BFX_OFS_STATUS) begin
        st_next.prdata = {15'h0000, st_reg.carry, 3'h0, st_reg.pc};
      end else if (8'(paddr) == `BFX_OFS_TARGET) begin
        st_next.prdata = {19'h00000, st_reg.target};
      end else if (8'(paddr) == `BFX_OFS_SELECTS) begin
        st_next.prdata = {16'h0000, st_reg.rsel, st_reg.lsel};
      end else if (8'(paddr) >= `BFX_OFS_REGBASE &&
                   8'(paddr) <= `BFX_OFS_REGLAST) begin
        // register window by code, write-only selects included
        if (ridx[3:0] == 4'h7) begin
          st_next.prdata = {24'h000000, st_reg.lsel};
        end else if (ridx[3:0] == 4'hF) begin
          st_next.prdata = {24'h000000, st_reg.rsel};
        end else begin
          st_next.prdata = {24'h000000,
            reg_read({1'b0, ridx[3:0]}, st_reg.regs, st_reg.carry)};
        end
      end else begin
        st_next.pslverr = 1'b1;   // unmapped address
      end
      if (paddr[1:0] != 2'b00 || paddr > ADDR_W'(`BFX_OFS_REGLAST)) begin
        st_next.pslverr = 1'b1;
        st_next.prdata  = 32'h0000_0000; // refused reads return zero
      end
    end

    // apb access: an instruction write starts execution
    if (psel && penable && st_reg.pready && pwrite && !st_reg.pslverr &&
        8'(paddr) == `BFX_OFS_INSTR) begin
      st_next.instr = pwdata[15:0];
      st_next.go    = 1'b1;
    end

    // execute: whole instruction in one cycle  RQ20
    if (st_reg.go) begin
      st_next.pc = 13'(st_reg.pc + 13'h0001);
      unique case (op)                                 // RQ18
        bfx_pkg::OP_MOVE, bfx_pkg::OP_ADD,
        bfx_pkg::OP_AND, bfx_pkg::OP_XOR: begin
          // source shaping
          if (s_code[4]) begin
            src = field_get(sbank, s_code[2:0], rl);   // RQ2 RQ6 RQ7
          end else if (!d_code[4]) begin
            src = rot_right(reg_read(s_code, st_reg.regs,
                                     st_reg.carry), rl);  // RQ9
          end else begin
            src = reg_read(s_code, st_reg.regs, st_reg.carry);
          end
          sum = {1'b0, src} + {1'b0, st_reg.regs[0]};
          unique case (op)
            bfx_pkg::OP_MOVE: res = src;                  // RQ8
            bfx_pkg::OP_ADD:  res = sum[7:0];             // RQ11
            bfx_pkg::OP_AND:  res = src & st_reg.regs[0]; // RQ13
            default:          res = src ^ st_reg.regs[0]; // RQ14
          endcase
          wr    = 1'b1;
          wcode = d_code;
        end
        bfx_pkg::OP_LITERAL_TRANSFER: begin
          // destination sits in the source position  RQ17
          wcode = s_code;
          res   = s_code[4] ? lit5 : lit8;
          wr    = 1'b1;
        end
        bfx_pkg::OP_INDIRECT_EXECUTE: begin
          // address register low bits from literal plus source  RQ15
          if (s_code[4]) begin
            xsum = 8'(lit5 + field_get(sbank, s_code[2:0], rl));
            st_next.target = {st_reg.pc[12:5], xsum[4:0]};
          end else begin
            xsum = 8'(lit8 + reg_read(s_code, st_reg.regs, st_reg.carry));
            st_next.target = {st_reg.pc[12:8], xsum};
          end
          st_next.pc = st_reg.pc;                      // RQ16
        end
        bfx_pkg::OP_NONZERO_BRANCH: begin
          // replace low pc bits when the source is nonzero
          if (s_code[4]) begin
            if (field_get(sbank, s_code[2:0], rl) != 8'h00) begin
              st_next.pc = {st_reg.pc[12:5], lit5[4:0]};
            end
          end else if (reg_read(s_code, st_reg.regs,
                                st_reg.carry) != 8'h00) begin
            st_next.pc = {st_reg.pc[12:8], lit8};
          end
        end
        bfx_pkg::OP_JUMP: begin
          st_next.pc = st_reg.instr[12:0];
        end
      endcase

      // destination write  RQ12
      if (wr) begin
        if (wcode[4]) begin
          wbank = wcode[3] ? right_bank_rdata : left_bank_rdata;
          if (wcode[3]) begin                          // RQ7
            st_next.right_wdata = field_put(wbank, wcode[2:0], rl, res);
            st_next.right_we    = 1'b1;
          end else begin                               // RQ6
            st_next.left_wdata = field_put(wbank, wcode[2:0], rl, res);
            st_next.left_we    = 1'b1;
          end
        end else if (wcode <= 5'h06) begin             // RQ5
          st_next.regs[wcode[2:0]] = res;
        end else if (wcode == `BFX_CODE_LSEL) begin    // RQ3
          st_next.lsel = res;
        end else if (wcode == `BFX_CODE_RSEL) begin    // RQ3
          st_next.rsel = res;
        end else if (wcode == `BFX_CODE_EXTRA) begin
          st_next.regs[`BFX_IDX_EXTRA] = res;
        end
        // carry code and unassigned codes take no write  RQ4 RQ21
      end
      if (op == bfx_pkg::OP_ADD) begin
        st_next.carry = sum[8];                        // RQ11 RQ4
      end
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg.instr    <= `BFX_RST_INSTR;
      st_reg.go       <= 1'b0;
      st_reg.regs     <= '0;
      st_reg.carry    <= 1'b0;
      st_reg.lsel     <= `BFX_RST_BYTE;
      st_reg.rsel     <= `BFX_RST_BYTE;
      st_reg.pc       <= `BFX_RST_PC;
      st_reg.target   <= `BFX_RST_PC;
      st_reg.left_wdata  <= `BFX_RST_BYTE;
      st_reg.left_we     <= 1'b0;
      st_reg.right_wdata <= `BFX_RST_BYTE;
      st_reg.right_we    <= 1'b0;
      st_reg.prdata   <= 32'h0000_0000;
      st_reg.pready   <= 1'b0;
      st_reg.pslverr  <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs straight from flip-flops
  // ---------------------------------------------------------------
  assign prdata                = st_reg.prdata;
  assign pready                = st_reg.pready;
  assign pslverr               = st_reg.pslverr;
  assign left_bank_select_reg  = st_reg.lsel;
  assign right_bank_select_reg = st_reg.rsel;
  assign left_bank_wdata       = st_reg.left_wdata;
  assign left_bank_we          = st_reg.left_we;
  assign right_bank_wdata      = st_reg.right_wdata;
  assign right_bank_we         = st_reg.right_we;

endmodule : bfx_exec_unit

// *** testbench/bfx_bank_model.sv ***
/*
  bank byte model: left and right banks of 256 bytes each.
  assumes: selects and write strobes come from the execute unit.
*/
`timescale 1ns/100ps
module bfx_bank_model (
  input  wire logic       pclk,
  input  wire logic [7:0] lsel,
  input  wire logic [7:0] rsel,
  input  wire logic [7:0] lwdata,
  input  wire logic       lwe,
  input  wire logic [7:0] rwdata,
  input  wire logic       rwe,
  output logic      [7:0] lrdata,
  output logic      [7:0] rrdata
);
  logic [7:0] lmem [256]; // left bank bytes
  logic [7:0] rmem [256]; // right bank bytes
  // distinct start pattern so merges show
  initial begin
    for (int i = 0; i < 256; i++) begin
      lmem[i] = 8'(i * 37 + 8'h5A);
      rmem[i] = 8'(i * 91 + 8'hC3);
    end
  end
  // byte at the current select, always driven
  assign lrdata = lmem[lsel];
  assign rrdata = rmem[rsel];
  // strobed write to the selected byte
  always @(posedge pclk) begin
    if (lwe) lmem[lsel] <= lwdata;
    if (rwe) rmem[rsel] <= rwdata;
  end
endmodule : bfx_bank_model

// *** testbench/bfx_exec_chk.sv ***
/*
  port checker of the execute unit, bound at the foot.
  assumes: zero-wait apb, one clock, async active-low reset.
*/
`timescale 1ns/100ps
module bfx_exec_chk #(
  parameter int ADDR_W = 8
) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic [7:0]        left_bank_select_reg,
  input wire logic [7:0]        right_bank_select_reg,
  input wire logic              left_bank_we,
  input wire logic              right_bank_we
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [2:0] op;  // opcode of the written word
  logic [4:0] dc;  // destination code
  logic       wr;  // op writes a destination
  logic       acc; // instruction write accepted
  logic       stp; // apb setup cycle
  assign op  = pwdata[15:13];
  assign dc  = (op == 3'h6) ? pwdata[12:8] : pwdata[4:0];
  assign wr  = (op < 3'h4) || (op == 3'h6);
  assign acc = psel && penable && pready && pwrite && (paddr == '0);
  assign stp = psel && !penable;
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  property p_ready; stp |=> pready ##1 !pready; endproperty
  a_ready: assert property (p_ready) else $error("bad ready");
  property p_err; stp && (paddr[1:0] != 2'b00 || paddr > 8'h7C ||
    paddr inside {[8'h10:8'h3C]}) |=> pslverr && (pwrite || prdata == '0);
  endproperty
  a_err: assert property (p_err) else $error("no error");
  property p_zero; stp && !pwrite && paddr inside {[8'h68:8'h78]}
    |=> prdata == '0; endproperty
  a_zero: assert property (p_zero) else $error("nonzero");
  property p_lwe; acc && wr && dc[4:3] == 2'b10 |-> ##2 left_bank_we;
  endproperty
  a_lwe: assert property (p_lwe) else $error("no left write");
  property p_rwe; acc && wr && dc[4:3] == 2'b11 |-> ##2 right_bank_we;
  endproperty
  a_rwe: assert property (p_rwe) else $error("no right write");
  property p_cause; left_bank_we || right_bank_we
    |-> $past(acc && wr && dc[4], 2); endproperty
  a_cause: assert property (p_cause) else $error("stray write");
  property p_keep; acc && op == 3'h0 && !pwdata[4]
    |-> ##2 !(left_bank_we || right_bank_we); endproperty
  a_keep: assert property (p_keep) else $error("source hit");
  property p_sel; $changed(left_bank_select_reg) ||
    $changed(right_bank_select_reg)
    |-> $past(acc && wr && !dc[4] && dc[2:0] == 3'h7, 2); endproperty
  a_sel: assert property (p_sel) else $error("select moved");
  c_lw: cover property (acc && wr && dc[4:3] == 2'b10);
  c_add: cover property (acc && op == 3'h1);
  c_err: cover property (pslverr);
endmodule : bfx_exec_chk

bind bfx_exec_unit bfx_exec_chk #(.ADDR_W(ADDR_W)) bfx_exec_chk_i (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .left_bank_select_reg(left_bank_select_reg),
  .right_bank_select_reg(right_bank_select_reg),
  .left_bank_we(left_bank_we), .right_bank_we(right_bank_we));

// *** testbench/bfx_exec_unit_tb_top.sv ***
/*
  self-checking bench of the execute unit with the bank byte model.
  assumes: design, bank model and checker compiled first.
*/
`timescale 1ns/100ps
module bfx_exec_unit_tb_top;
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, er, lwe, rwe, eside, eon;
  logic [7:0]  lrd, rrd, lsel, rsel, lwd, rwd, eaddr, eval;
  logic [7:0]  m_reg [16];   // expected value per register code
  logic [12:0] m_pc, m_tgt;  // expected pc and target
  logic [15:0] ins;
  int          miscompares = 0;
  int          cmp_count   = 0;
  int          seed        = 40697;
  logic [15:0] corner [21] = '{16'hC705, 16'hCF22, 16'hC0FF, 16'hC101,
    16'h2103, 16'hC855, 16'hCC77, 16'hC93C, 16'h0182, 16'h0173, 16'h1A84,
    16'h171F, 16'hD0BB, 16'h8110, 16'h9443, 16'hA133, 16'h0805, 16'h0706,
    16'h4206, 16'h74B4, 16'hFABC};
  logic [7:0]  bad [3] = '{8'h10, 8'h41, 8'h80};
  always #2.5 pclk = ~pclk;
  bfx_exec_unit bfx_exec_unit_i (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .left_bank_rdata(lrd), .right_bank_rdata(rrd),
    .left_bank_select_reg(lsel), .right_bank_select_reg(rsel),
    .left_bank_wdata(lwd), .left_bank_we(lwe),
    .right_bank_wdata(rwd), .right_bank_we(rwe));
  bfx_bank_model bfx_bank_model_i (.pclk(pclk), .lsel(lsel), .rsel(rsel),
    .lwdata(lwd), .lwe(lwe), .rwdata(rwd), .rwe(rwe), .lrdata(lrd),
    .rrdata(rrd));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  // one apb transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // wait for the answer; only the watchdog ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // field mask: low bit at 7-p, l bits upward, 0 means 8
  function automatic logic [7:0] fmask(input logic [2:0] p, l);
    return 8'(((16'h1 << ((l == 3'h0) ? 8 : l)) - 16'h1) << (7 - p));
  endfunction : fmask
  function automatic logic [7:0] bank(input logic side);
    return side ? bfx_bank_model_i.rmem[m_reg[15]]
                : bfx_bank_model_i.lmem[m_reg[7]];
  endfunction : bank
  // expected effect of one instruction
  task automatic step(input logic [15:0] i);
    logic [2:0] op, rl;
    logic [4:0] s, d;
    logic [7:0] v, r, m;
    logic [8:0] sum;
    op = i[15:13];
    s  = i[12:8];
    rl = i[7:5];
    d  = (op == 3'h6) ? s : i[4:0];
    m  = fmask(s[2:0], rl);
    if (s[4]) v = (bank(s[3]) & m) >> (7 - s[2:0]);
    else v = (s[2:0] == 3'h7) ? 8'h00 : m_reg[s[3:0]];
    if (!s[4] && !i[4] && op < 3'h4) v = (v >> rl) | (v << (8 - rl));
    sum = 9'(v) + 9'(m_reg[0]);
    r   = (op == 3'h2) ? (v & m_reg[0]) : (op == 3'h3) ? (v ^ m_reg[0]) : v;
    if (op == 3'h1) r = sum[7:0];
    if (op == 3'h6) r = s[4] ? {3'h0, i[4:0]} : i[7:0];
    if (op == 3'h1) m_reg[8] = {7'h00, sum[8]};
    case (op)
      3'h4: m_tgt = s[4] ? {m_pc[12:5], i[4:0] + v[4:0]}
                         : {m_pc[12:8], i[7:0] + v};
      3'h5: m_pc = (v == 8'h00) ? 13'(m_pc + 1) : s[4]
                   ? {m_pc[12:5], i[4:0]} : {m_pc[12:8], i[7:0]};
      3'h7: m_pc = i[12:0];
      default: begin
        m_pc = 13'(m_pc + 1);
        if (d[4]) begin
          eon   = 1'b1;
          eside = d[3];
          eaddr = d[3] ? m_reg[15] : m_reg[7];
          m     = fmask(d[2:0], rl);
          eval  = (bank(d[3]) & ~m) | (8'(16'(r) << (7 - d[2:0])) & m);
        end else if (d != 5'h08 && (d < 5'h0A || d == 5'h0F)) begin
          m_reg[d[3:0]] = r;
        end
      end
    endcase
  endtask : step
  // read back every visible place but the instruction word, and the bank byte written
  task automatic verify;
    for (int k = 0; k < 16; k++) begin
      apb(1'b0, 8'(8'h40 + 4 * k), 32'h0);
      check(rd, {24'h0, m_reg[k]});
    end
    apb(1'b0, 8'h04, 32'h0);
    check(rd, {15'h0, m_reg[8][0], 3'h0, m_pc});
    apb(1'b0, 8'h08, 32'h0);
    check(rd, {19'h0, m_tgt});
    apb(1'b0, 8'h0C, 32'h0);
    check(rd, {16'h0, m_reg[15], m_reg[7]});
    check({16'h0, lsel, rsel}, {16'h0, m_reg[7], m_reg[15]});
    if (eon) check({24'h0, eside ? bfx_bank_model_i.rmem[eaddr]
                                 : bfx_bank_model_i.lmem[eaddr]},
                   {24'h0, eval});
  endtask : verify
  task automatic exec(input logic [15:0] i);
    eon = 1'b0;
    step(i);
    apb(1'b1, 8'h00, {16'h0, i});
    repeat (3) @(posedge pclk);
    verify();
    apb(1'b0, 8'h00, 32'h0);
    check(rd, {16'h0, i});
  endtask : exec
  task automatic summarize;
    $display("compares %0d, miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : summarize
  // main sequence
  initial begin
    foreach (m_reg[k]) m_reg[k] = 8'h00;
    m_pc  = 13'h0;
    m_tgt = 13'h0;
    eon   = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    verify();
    foreach (bad[j]) begin
      apb(1'b0, bad[j], 32'h0);
      check({31'h0, er}, 32'h1);
      check(rd, 32'h0);
    end
    apb(1'b1, 8'h04, 32'h1234);
    check({31'h0, er}, 32'h0);
    foreach (corner[j]) exec(corner[j]);
    for (int n = 0; n < 80; n++) begin
      ins = 16'($random(seed));
      if (!ins[15] && ins[12] && ins[4]) ins[7:5] = 3'h0;
      exec(ins);
    end
    summarize();
  end
  // watchdog
  initial begin
    #200000;
    miscompares++;
    summarize();
  end
endmodule : bfx_exec_unit_tb_top
